// ==== rtl/ufl_ctrl.sv ====
// Decided for this implementation: the Wishbone interface to the registers.
`include "ufl_consts.svh"

module ufl_ctrl
    import ufl_pkg::*;
#(
    parameter int DEPTH = 15,
    parameter int LIN_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    input wire logic tx_pop_i,
    output logic [7:0] tx_byte_o,
    output logic tx_avail_o,
    input wire logic lin_frame_tick_i,
    output logic [LIN_W-1:0] lin_frame_counter_o,
    output logic serial_port_enable_o,
    output logic [15:0] baud_divisor_o,
    output logic rx_threshold_ready_flag_o,
    output logic tx_ready_flag_o,
    output logic rx_overflow_flag_o,
    output logic rx_underflow_flag_o,
    output logic tx_overflow_flag_o,
    output logic irq_o
);

    localparam int CW = 4;

    ufl_fifo_if #(.WIDTH(8), .CW(CW)) rx_q ();
    ufl_fifo_if #(.WIDTH(8), .CW(CW)) tx_q ();

    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_idx;
    logic [31:0] reg_rdata;

    ufl_nib_t rx_trigger_threshold;
    ufl_nib_t tx_trigger_threshold;
    logic serial_port_enable;
    logic [15:0] baud_divisor;
    logic [`UFL_ST_W-1:0] status;
    logic [`UFL_ST_W-1:0] mask;
    logic [LIN_W-1:0] lin_frame_counter;
    logic [7:0] tx_byte;
    logic tx_avail;
    logic irq;

    ufl_nib_t next_rx_thr;
    ufl_nib_t next_tx_thr;
    logic next_enable;
    logic [15:0] next_baud;
    logic [`UFL_ST_W-1:0] next_status;
    logic [`UFL_ST_W-1:0] next_mask;
    logic [LIN_W-1:0] next_lin;
    logic [7:0] next_tx_byte;
    logic next_tx_avail;
    logic next_irq;

    logic wr_data;
    logic wr_fifo;
    logic wr_ctrl;
    logic wr_baud;
    logic wr_mask;
    logic rd_data;
    logic rd_stat;
    logic clear_op;
    logic rx_ovf_evt;
    logic rx_udf_evt;
    logic tx_ovf_evt;
    ufl_nib_t rx_code;
    ufl_nib_t tx_code;

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction

    ufl_wb_slave #(.AW(10)) u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd),
        .reg_idx_o(reg_idx),
        .reg_rdata_i(reg_rdata)
    );

    ufl_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .port(rx_q.store)
    );

    ufl_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .port(tx_q.store)
    );

    // Register strobes; byte lanes gate every write
    assign wr_data = reg_wr & hit(reg_idx, `UFL_IDX_DATA) & wb_sel_i[0];
    assign wr_fifo = reg_wr & hit(reg_idx, `UFL_IDX_FIFO) & wb_sel_i[0];
    assign wr_ctrl = reg_wr & hit(reg_idx, `UFL_IDX_CTRL) & wb_sel_i[0];
    assign wr_baud = reg_wr & hit(reg_idx, `UFL_IDX_BAUD) & (|wb_sel_i[1:0]);
    assign wr_mask = reg_wr & hit(reg_idx, `UFL_IDX_MASK) & wb_sel_i[0];
    assign rd_data = reg_rd & hit(reg_idx, `UFL_IDX_DATA);
    assign rd_stat = reg_rd & hit(reg_idx, `UFL_IDX_STAT);

    assign rx_code = wb_dat_i[`UFL_RXTHR_LSB +: 4];
    assign tx_code = wb_dat_i[`UFL_TXTHR_LSB +: 4];

    always_comb begin
        next_enable = serial_port_enable;
        next_baud = baud_divisor;
        if (wr_ctrl) begin
            next_enable = wb_dat_i[`UFL_CTRL_EN_BIT];
        end
        if (wr_baud && wb_sel_i[0]) begin
            next_baud[7:0] = wb_dat_i[7:0];
        end
        if (wr_baud && wb_sel_i[1]) begin
            next_baud[15:8] = wb_dat_i[15:8];
        end
    end

    // Acts once per control or divisor write that leaves the port stopped at divisor zero
    assign clear_op = (wr_ctrl | wr_baud) & (next_baud == 16'h0000) & ~next_enable;

    // FIFO controls
    always_comb begin
        rx_q.flush = clear_op;
        tx_q.flush = clear_op;
        if (wr_fifo && rx_code == `UFL_RX_RESET_CODE) begin
            rx_q.flush = 1'b1;
        end
        if (wr_fifo && tx_code == `UFL_TX_RESET_CODE) begin
            tx_q.flush = 1'b1;
        end
        rx_q.push = rx_valid_i;
        rx_q.wdata = rx_byte_i;
        rx_q.pop = rd_data;
        tx_q.push = wr_data;
        tx_q.wdata = wb_dat_i[7:0];
        tx_q.pop = tx_pop_i;
    end

    // Events lost to a simultaneous flush are not reported
    assign rx_ovf_evt = rx_valid_i & rx_q.full & ~rx_q.flush;
    assign rx_udf_evt = rd_data & rx_q.empty & ~rx_q.flush;
    assign tx_ovf_evt = wr_data & tx_q.full & ~tx_q.flush;

    // Reset codes leave the previous trigger level in force
    always_comb begin
        next_rx_thr = rx_trigger_threshold;
        next_tx_thr = tx_trigger_threshold;
        if (wr_fifo && rx_code != `UFL_RX_RESET_CODE) begin
            next_rx_thr = rx_code;
        end
        if (wr_fifo && tx_code != `UFL_TX_RESET_CODE) begin
            next_tx_thr = tx_code;
        end
    end

    // Sticky events: read of status clears, a new event in the same cycle wins
    always_comb begin
        next_status = status;
        if (rd_stat) begin
            next_status[`UFL_ST_RXOVF] = 1'b0;
            next_status[`UFL_ST_RXUDF] = 1'b0;
            next_status[`UFL_ST_TXOVF] = 1'b0;
        end
        if (clear_op) begin
            next_status[`UFL_ST_RXOVF] = 1'b0;
            next_status[`UFL_ST_RXUDF] = 1'b0;
            next_status[`UFL_ST_TXOVF] = 1'b0;
        end
        if (rx_ovf_evt) begin
            next_status[`UFL_ST_RXOVF] = 1'b1;
        end
        if (rx_udf_evt) begin
            next_status[`UFL_ST_RXUDF] = 1'b1;
        end
        if (tx_ovf_evt) begin
            next_status[`UFL_ST_TXOVF] = 1'b1;
        end
        // Level flags follow the counts, one cycle behind
        next_status[`UFL_ST_TXRDY] = (tx_q.count < tx_trigger_threshold);
        next_status[`UFL_ST_RXRDY] = (rx_q.count > rx_trigger_threshold);
    end

    always_comb begin
        next_mask = mask;
        if (wr_mask) begin
            next_mask = wb_dat_i[`UFL_ST_W-1:0];
        end
        next_irq = |(next_status & next_mask);
    end

    always_comb begin
        next_lin = lin_frame_counter;
        if (clear_op) begin
            next_lin = '0;
        end else if (lin_frame_tick_i) begin
            next_lin = lin_frame_counter + 1'b1;
        end
    end

    // Avail drops the cycle after a pop so a stale head is never offered twice
    always_comb begin
        next_tx_byte = tx_q.rdata;
        next_tx_avail = ~tx_q.empty & ~tx_pop_i & ~tx_q.flush;
    end

    always_comb begin
        reg_rdata = 32'h0000_0000;
        case (reg_idx)
            `UFL_IDX_DATA: begin
                reg_rdata[7:0] = rx_q.empty ? 8'h00 : rx_q.rdata;
            end
            `UFL_IDX_FIFO: begin
                reg_rdata[7:0] = {rx_q.count, tx_q.count};
            end
            `UFL_IDX_CTRL: begin
                reg_rdata[`UFL_CTRL_EN_BIT] = serial_port_enable;
            end
            `UFL_IDX_BAUD: begin
                reg_rdata[15:0] = baud_divisor;
            end
            `UFL_IDX_STAT: begin
                reg_rdata[`UFL_ST_W-1:0] = status;
            end
            `UFL_IDX_MASK: begin
                reg_rdata[`UFL_ST_W-1:0] = mask;
            end
            `UFL_IDX_LIN: begin
                reg_rdata[LIN_W-1:0] = lin_frame_counter;
            end
            default: begin
                reg_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_trigger_threshold <= ufl_nib_t'(`UFL_FIFO_RST >> `UFL_RXTHR_LSB);
            tx_trigger_threshold <= ufl_nib_t'(`UFL_FIFO_RST);
            serial_port_enable <= 1'b0;
            baud_divisor <= `UFL_BAUD_RST;
            status <= `UFL_STAT_RST;
            mask <= `UFL_MASK_RST;
            lin_frame_counter <= '0;
            tx_byte <= 8'h00;
            tx_avail <= 1'b0;
            irq <= 1'b0;
        end else begin
            rx_trigger_threshold <= next_rx_thr;
            tx_trigger_threshold <= next_tx_thr;
            serial_port_enable <= next_enable;
            baud_divisor <= next_baud;
            status <= next_status;
            mask <= next_mask;
            lin_frame_counter <= next_lin;
            tx_byte <= next_tx_byte;
            tx_avail <= next_tx_avail;
            irq <= next_irq;
        end
    end

    assign serial_port_enable_o = serial_port_enable;
    assign baud_divisor_o = baud_divisor;
    assign lin_frame_counter_o = lin_frame_counter;
    assign tx_byte_o = tx_byte;
    assign tx_avail_o = tx_avail;
    assign irq_o = irq;
    assign tx_ready_flag_o = status[`UFL_ST_TXRDY];
    assign rx_threshold_ready_flag_o = status[`UFL_ST_RXRDY];
    assign rx_overflow_flag_o = status[`UFL_ST_RXOVF];
    assign rx_underflow_flag_o = status[`UFL_ST_RXUDF];
    assign tx_overflow_flag_o = status[`UFL_ST_TXOVF];

endmodule

// ==== pkg/ufl_consts.svh ====
`ifndef UFL_CONSTS_SVH
`define UFL_CONSTS_SVH

// Register indices; byte address is four times the index
`define UFL_IDX_DATA 8'ha4
`define UFL_IDX_FIFO 8'ha5
`define UFL_IDX_CTRL 8'ha6
`define UFL_IDX_BAUD 8'ha8
`define UFL_IDX_STAT 8'ha9
`define UFL_IDX_MASK 8'haa
`define UFL_IDX_LIN 8'hab

// Reset values
`define UFL_FIFO_RST 8'h00
`define UFL_BAUD_RST 16'h0000
`define UFL_STAT_RST 5'h00
`define UFL_MASK_RST 5'h00

// Threshold fields of the FIFO register
`define UFL_RXTHR_LSB 4
`define UFL_TXTHR_LSB 0
`define UFL_RX_RESET_CODE 4'hf
`define UFL_TX_RESET_CODE 4'h0

// Control register
`define UFL_CTRL_EN_BIT 0

// Status and mask layout
`define UFL_ST_TXRDY 0
`define UFL_ST_RXRDY 1
`define UFL_ST_RXOVF 2
`define UFL_ST_RXUDF 3
`define UFL_ST_TXOVF 4
`define UFL_ST_W 5

`endif

// ==== pkg/ufl_pkg.sv ====
package ufl_pkg;

    typedef enum logic [1:0] {
        UFL_WB_IDLE = 2'b01,
        UFL_WB_ACK = 2'b10
    } ufl_wb_state_t;

    typedef logic [3:0] ufl_nib_t;

endpackage

// ==== pkg/ufl_fifo_if.sv ====
interface ufl_fifo_if #(
    parameter int WIDTH = 8,
    parameter int CW = 4
);
    logic push;
    logic pop;
    logic flush;
    logic [WIDTH-1:0] wdata;
    logic [WIDTH-1:0] rdata;
    logic [CW-1:0] count;
    logic full;
    logic empty;

    modport store (
        input push, pop, flush, wdata,
        output rdata, count, full, empty
    );

    modport user (
        output push, pop, flush, wdata,
        input rdata, count, full, empty
    );
endinterface

// ==== rtl/ufl_fifo.sv ====
module ufl_fifo
    import ufl_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 15,
    parameter int CW = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    ufl_fifo_if.store port
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [CW-1:0] rd_ptr;
    logic [CW-1:0] wr_ptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_rd_ptr;
    logic [CW-1:0] next_wr_ptr;
    logic [CW-1:0] next_count;
    logic do_push;
    logic do_pop;

    function automatic logic [CW-1:0] ptr_inc(input logic [CW-1:0] p);
        ptr_inc = (p == CW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign port.full = (count == CW'(DEPTH));
    assign port.empty = (count == '0);
    assign port.count = count;
    assign port.rdata = mem[rd_ptr];

    // A push into a full store or a pop from an empty one is dropped
    assign do_push = port.push & ~port.full & ~port.flush;
    assign do_pop = port.pop & ~port.empty & ~port.flush;

    always_comb begin
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_count = count;
        if (port.flush) begin
            next_rd_ptr = '0;
            next_wr_ptr = '0;
            next_count = '0;
        end else begin
            if (do_push) begin
                next_wr_ptr = ptr_inc(wr_ptr);
            end
            if (do_pop) begin
                next_rd_ptr = ptr_inc(rd_ptr);
            end
            if (do_push && !do_pop) begin
                next_count = count + 1'b1;
            end else if (do_pop && !do_push) begin
                next_count = count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count <= next_count;
        end
    end

    // Storage needs no reset; the count guards it
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= port.wdata;
        end
    end

endmodule

// ==== rtl/ufl_wb_slave.sv ====
module ufl_wb_slave
    import ufl_pkg::*;
#(
    parameter int AW = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [AW-3:0] reg_idx_o,
    input wire logic [31:0] reg_rdata_i
);

    ufl_wb_state_t state;
    ufl_wb_state_t next_state;
    logic next_ack;
    logic [31:0] next_dat;
    logic req;

    // Only the idle state takes a request, so a strobe held through the ack cycle acts once
    assign req = (state == UFL_WB_IDLE) & wb_cyc_i & wb_stb_i;
    assign reg_wr_o = req & wb_we_i;
    assign reg_rd_o = req & ~wb_we_i;
    assign reg_idx_o = wb_adr_i[AW-1:2];

    always_comb begin
        next_state = state;
        next_ack = 1'b0;
        next_dat = wb_dat_o;
        case (state)
            UFL_WB_IDLE: begin
                if (req) begin
                    next_state = UFL_WB_ACK;
                    next_ack = 1'b1;
                    next_dat = reg_rdata_i;
                end
            end
            UFL_WB_ACK: begin
                next_state = UFL_WB_IDLE;
            end
            default: begin
                next_state = UFL_WB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= UFL_WB_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            state <= next_state;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

endmodule

// ==== dv/ufl_line_model.sv ====
module ufl_line_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic drain_i,
    input wire logic tx_avail_i,
    input wire logic [7:0] tx_byte_i,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic tx_pop_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got [$];
    initial begin
        rx_byte_o <= 8'h00;
        rx_valid_o <= 1'b0;
        tx_pop_o <= 1'b0;
    end
    // Back to back bytes; idle data inverted so stale bytes never look valid
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            rx_byte_o <= b + 8'(i);
            rx_valid_o <= 1'b1;
            @(posedge clk_i);
        end
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~(b + 8'(n - 1));
    endtask
    // Pop once, then wait for tx_avail_i to come back before the next
    always @(posedge clk_i) begin
        if (tx_pop_o) begin
            tx_pop_o <= 1'b0;
        end else if (drain_i && tx_avail_i === 1'b1 && !rst_i) begin
            tx_pop_o <= 1'b1;
            got.push_back(tx_byte_i);
        end
    end
endmodule

// ==== dv/ufl_ctrl_props.sv ====
`include "ufl_consts.svh"
module ufl_ctrl_props
    import ufl_pkg::*;
#(
    parameter int DEPTH = 15,
    parameter int LIN_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic rx_valid_i,
    input wire logic tx_pop_i,
    input wire logic tx_avail_o,
    input wire logic lin_frame_tick_i,
    input wire logic [LIN_W-1:0] lin_frame_counter_o,
    input wire logic serial_port_enable_o,
    input wire logic [15:0] baud_divisor_o,
    input wire logic rx_overflow_flag_o,
    input wire logic rx_underflow_flag_o,
    input wire logic tx_overflow_flag_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic clr;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign clr = take && wb_we_i && !lin_frame_tick_i && wb_sel_i[0]
        && ((wb_adr_i[9:2] == `UFL_IDX_CTRL && !wb_dat_i[0] && baud_divisor_o == 16'h0000)
        || (wb_adr_i[9:2] == `UFL_IDX_BAUD && wb_sel_i[1] && wb_dat_i[15:0] == 16'h0000
        && !serial_port_enable_o));
    property p_ack;
        take |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("request not answered in one cycle");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_clear;
        clr |=> !rx_overflow_flag_o && !rx_underflow_flag_o && !tx_overflow_flag_o
            && lin_frame_counter_o == '0 ##1 !tx_avail_o;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left state behind");
    property p_rx_ovf;
        $rose(rx_overflow_flag_o) |-> $past(rx_valid_i) || $past(rx_valid_i, 2);
    endproperty
    a_rx_ovf: assert property (p_rx_ovf) else $error("overflow without a byte");
    property p_sticky;
        rx_overflow_flag_o && !(wb_cyc_i && wb_stb_i) |=> rx_overflow_flag_o;
    endproperty
    a_sticky: assert property (p_sticky) else $error("overflow flag lost");
    property p_udf;
        $rose(rx_underflow_flag_o) |-> wb_ack_o || $past(wb_ack_o);
    endproperty
    a_udf: assert property (p_udf) else $error("underflow without a read");
    property p_tx_ovf;
        $rose(tx_overflow_flag_o) |-> (wb_ack_o || $past(wb_ack_o)) && $past(wb_we_i);
    endproperty
    a_tx_ovf: assert property (p_tx_ovf) else $error("tx overflow without a write");
    property p_pop;
        tx_pop_i && tx_avail_o |=> !tx_avail_o;
    endproperty
    a_pop: assert property (p_pop) else $error("tx_avail_o held after pop");
    property p_cfg;
        !$stable({serial_port_enable_o, baud_divisor_o}) |-> wb_ack_o && $past(wb_we_i);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config changed without a write");
endmodule
bind ufl_ctrl ufl_ctrl_props #(.DEPTH(DEPTH), .LIN_W(LIN_W)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .tx_pop_i(tx_pop_i),
    .tx_avail_o(tx_avail_o), .lin_frame_tick_i(lin_frame_tick_i),
    .lin_frame_counter_o(lin_frame_counter_o), .serial_port_enable_o(serial_port_enable_o),
    .baud_divisor_o(baud_divisor_o), .rx_overflow_flag_o(rx_overflow_flag_o),
    .rx_underflow_flag_o(rx_underflow_flag_o), .tx_overflow_flag_o(tx_overflow_flag_o));

// ==== dv/tb.sv ====
`include "ufl_consts.svh"
`define CHK(a, e) begin \
    num_checks++; \
    if ((a) !== (e)) begin \
        miscompares++; \
        $display("MISMATCH %0t got %h exp %h", $time, a, e); \
    end \
end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic drain = 1'b0;
    logic lin_tick = 1'b0;
    logic [9:0] wb_adr = 10'h000;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_dat_o, q;
    logic [7:0] rx_byte, tx_byte, lin;
    logic [15:0] baud;
    logic wb_ack_o, rx_valid, tx_pop, tx_avail, en, rxrdy, txrdy, rxovf, rxudf, txovf, irq;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    always #10 clk_i = ~clk_i;
    ufl_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
        .tx_pop_i(tx_pop), .tx_byte_o(tx_byte), .tx_avail_o(tx_avail),
        .lin_frame_tick_i(lin_tick), .lin_frame_counter_o(lin), .serial_port_enable_o(en),
        .baud_divisor_o(baud), .rx_threshold_ready_flag_o(rxrdy), .tx_ready_flag_o(txrdy),
        .rx_overflow_flag_o(rxovf), .rx_underflow_flag_o(rxudf),
        .tx_overflow_flag_o(txovf), .irq_o(irq));
    ufl_line_model line (.clk_i(clk_i), .rst_i(rst_i), .drain_i(drain), .tx_avail_i(tx_avail),
        .tx_byte_i(tx_byte), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .tx_pop_o(tx_pop));
    task automatic wrap_up();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    // Ack is read as sampled at the edge, before the design's own updates land
    task automatic bus(input logic we, input logic [7:0] idx, input logic [15:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {16'h0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic push(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) bus(1'b1, `UFL_IDX_DATA, {8'h00, b + 8'(i)});
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_i);
    endtask
    task automatic t_regs();
        bus(1'b0, `UFL_IDX_FIFO, 16'h0000);
        `CHK(q, 32'h0000_0000)
        bus(1'b1, 8'h00, 16'h00ff);
        bus(1'b0, 8'h00, 16'h0000);
        `CHK(q, 32'h0000_0000)
        bus(1'b0, `UFL_IDX_MASK, 16'h0000);
        `CHK(q, 32'h0000_0000)
        `CHK({en, txrdy, rxrdy, irq, tx_avail, baud}, 21'h00_0000)
    endtask
    task automatic t_levels();
        bus(1'b1, `UFL_IDX_FIFO, 16'h00e1);
        `CHK(txrdy, 1'b1)
        push(1, 8'h10);
        `CHK(txrdy, 1'b0)
        bus(1'b1, `UFL_IDX_FIFO, 16'h00ef);
        push(13, 8'h11);
        `CHK(txrdy, 1'b1)
        push(1, 8'h1e);
        `CHK(txrdy, 1'b0)
        push(1, 8'hee);
        bus(1'b0, `UFL_IDX_FIFO, 16'h0000);
        `CHK(q[7:0], 8'h0f)
        `CHK(txovf, 1'b1)
        line.send(8'h40, 14);
        settle();
        bus(1'b0, `UFL_IDX_FIFO, 16'h0000);
        `CHK(q[7:0], 8'hef)
        `CHK(rxrdy, 1'b0)
        line.send(8'h4e, 2);
        settle();
        `CHK(rxrdy, 1'b1)
        `CHK(rxovf, 1'b1)
        bus(1'b0, `UFL_IDX_DATA, 16'h0000);
        `CHK(q[7:0], 8'h40)
    endtask
    task automatic t_drain();
        drain <= 1'b1;
        while (line.got.size() < 15) @(posedge clk_i);
        settle();
        drain <= 1'b0;
        `CHK(line.got[0], 8'h10)
        `CHK(line.got[14], 8'h1e)
        `CHK(txrdy, 1'b1)
        `CHK(tx_avail, 1'b0)
    endtask
    task automatic t_irq();
        bus(1'b1, `UFL_IDX_MASK, 16'h0004);
        `CHK(irq, 1'b1)
        bus(1'b0, `UFL_IDX_STAT, 16'h0000);
        `CHK(q[4:2], 3'b101)
        `CHK({irq, rxovf, txovf}, 3'b000)
        bus(1'b1, `UFL_IDX_MASK, 16'h0001);
        `CHK(irq, 1'b1)
        bus(1'b1, `UFL_IDX_MASK, 16'h0000);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_codes();
        bus(1'b1, `UFL_IDX_FIFO, 16'h00f5);
        bus(1'b0, `UFL_IDX_FIFO, 16'h0000);
        `CHK(q[7:0], 8'h00)
        `CHK(txrdy, 1'b1)
        push(5, 8'h20);
        `CHK(txrdy, 1'b0)
        bus(1'b1, `UFL_IDX_FIFO, 16'h0000);
        bus(1'b0, `UFL_IDX_FIFO, 16'h0000);
        `CHK(q[7:0], 8'h00)
        `CHK(txrdy, 1'b1)
        line.send(8'h66, 1);
        settle();
        `CHK(rxrdy, 1'b1)
        bus(1'b0, `UFL_IDX_DATA, 16'h0000);
        `CHK(q[7:0], 8'h66)
        bus(1'b0, `UFL_IDX_DATA, 16'h0000);
        `CHK({q[7:0], rxudf}, 9'h001)
    endtask
    task automatic t_clear();
        lin_tick <= 1'b1;
        repeat (3) @(posedge clk_i);
        lin_tick <= 1'b0;
        push(2, 8'h30);
        line.send(8'h50, 2);
        bus(1'b1, `UFL_IDX_CTRL, 16'h0001);
        bus(1'b1, `UFL_IDX_BAUD, 16'h0000);
        bus(1'b0, `UFL_IDX_LIN, 16'h0000);
        `CHK(q[7:0], 8'h03)
        `CHK(lin, 8'h03)
        `CHK({rxudf, en}, 2'b11)
        bus(1'b0, `UFL_IDX_FIFO, 16'h0000);
        `CHK(q[7:0], 8'h22)
        bus(1'b1, `UFL_IDX_CTRL, 16'h0000);
        `CHK(rxudf, 1'b0)
        bus(1'b0, `UFL_IDX_FIFO, 16'h0000);
        `CHK(q[7:0], 8'h00)
        bus(1'b0, `UFL_IDX_LIN, 16'h0000);
        `CHK(q[7:0], 8'h00)
        `CHK(lin, 8'h00)
        push(1, 8'h31);
        bus(1'b0, `UFL_IDX_FIFO, 16'h0000);
        `CHK(q[7:0], 8'h01)
        bus(1'b1, `UFL_IDX_BAUD, 16'h0000);
        bus(1'b0, `UFL_IDX_FIFO, 16'h0000);
        `CHK(q[7:0], 8'h00)
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        t_regs();
        t_levels();
        t_drain();
        t_irq();
        t_codes();
        t_clear();
        wrap_up();
    end
endmodule
